// ---- logic/tfhd_pkg.sv ----
// shared constants and carrier types of the tx frame header decoder
package tfhd_pkg;

  // register offsets on the plain register port (byte addresses)
  localparam logic [7:0] ctrl_reg_off      = 8'h00;
  localparam logic [7:0] hdr_word0_reg_off = 8'h04;
  localparam logic [7:0] frame_id_reg_off  = 8'h08;
  localparam logic [7:0] frame_cnt_reg_off = 8'h0C;
  localparam logic [7:0] frame_len_reg_off = 8'h10;

  // control register fields and reset value
  localparam int          ctrl_tag_ins_bit  = 0;
  localparam int          ctrl_offload_bit  = 1;
  localparam logic [31:0] ctrl_reset_val    = 32'h0000_0000;

  // header word 0 field positions
  localparam int word_cnt_lsb      = 18;
  localparam int word_cnt_msb      = 30;
  localparam int last_bytes_lsb    = 16;
  localparam int last_bytes_msb    = 17;
  localparam int use_seq_bit       = 15;
  localparam int force_trailer_bit = 14;
  localparam int suppress_bit      = 13;
  localparam int one_step_bit      = 12;
  localparam int timestamp_bit     = 11;
  localparam int incl_filter_bit   = 9;
  localparam int forced_fwd_bit    = 8;
  localparam int offload_off_bit   = 5;
  localparam int vlan_bit          = 4;
  localparam int crc_incl_bit      = 3;
  localparam int auto_pad_bit      = 2;

  // header word 1 field positions with switch tagging on
  localparam int seq_lsb       = 16;
  localparam int seq_msb       = 31;
  localparam int port_mask_lsb = 8;
  localparam int port_mask_msb = 11;
  localparam int short_id_msb  = 7;

  // length arithmetic constants
  localparam logic [14:0] len_bias        = 15'h0003;
  localparam logic [14:0] offload_pad_sz  = 15'h0002;
  localparam logic [12:0] min_frame_words = 13'h000F; // 60 bytes before crc
  localparam logic [14:0] min_frame_bytes = 15'h003C;

  // bpdu group destination address, first six octets
  localparam logic [47:0] bpdu_dest = 48'h0000_00C2_8001;

  // decoder states
  typedef enum logic [2:0] {
    st_hdr0,
    st_hdr1,
    st_data,
    st_pad
  } tfhd_state_t;

  // per-frame transmit controls handed to the mac and switch
  typedef struct packed {
    logic       vlan_tagged;
    logic       append_crc;
    logic       pad_short;
    logic       offload_active;
    logic       trailer_force;
    logic       trailer_use_seq;
    logic       trailer_suppress;
    logic       one_step;
    logic       timestamp;
    logic       forced_fwd;
    logic [3:0] port_mask;
    logic       filter_disabled;
    logic [15:0] seq_num;
    logic [31:0] frame_id;
    logic [14:0] frame_bytes;
  } tfhd_ctl_t;

  // one word of frame data toward the mac
  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  nbytes;
    logic        last;
  } tfhd_word_t;

endpackage : tfhd_pkg

// ---- logic/tfhd_decoder.sv ----
// tx frame header decoder: splits header from frame words, drives controls
//
// Behaviour
// - frame begins with two-word control header
// - read exactly word-count frame words after header
// - last-word code 00..11 means 1..4 bytes
// - length equals bytes minus pad plus three
// - offload filler excluded from counted length
// - vlan bit marks tagged frame data
// - crc included: no append, ignore auto pad
// - auto pad short frames to minimum
// - switch fields only with tag insertion on
// - word1 split by tagging, else frame id
// - provided sequence used when trailer forced
// - sequence bit honoured only with force bit
// - force trailer only while suppress clear
// - suppress trailer on prp ports
// - one-step correction update request passed on
// - transmit timestamp capture request passed on
// - forced forwarding to header-selected ports
// - four port mask bits pick ports
// - forced-forwarded bpdu: include bit picks disabled-port filtering
// - non-bpdu frames always filtered
//
// The strobed register port and the address map are this design's own decisions.
module tfhd_decoder (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_b,
  // register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // transmit fifo words from the dma side
  input  wire logic [31:0]        fifo_data,
  input  wire logic               fifo_valid,
  output logic                    fifo_ready,
  // frame words toward the mac
  output tfhd_pkg::tfhd_word_t    mac_word,
  output logic                    mac_valid,
  input  wire logic               mac_ready,
  // per-frame controls, valid from header end to frame end
  output tfhd_pkg::tfhd_ctl_t     frame_ctl,
  output logic                    frame_active
);

  // state and counters
  tfhd_pkg::tfhd_state_t state_reg;      // decoder state
  tfhd_pkg::tfhd_state_t state_next;     // next decoder state
  logic [31:0]           ctrl_reg;       // software control bits
  logic [31:0]           hdr0_reg;       // captured header word 0
  logic [31:0]           frame_cnt_reg;  // frames delivered to mac
  logic [12:0]           words_left_reg; // frame words still to read
  logic [12:0]           words_out_reg;  // words sent in this frame
  logic [1:0]            last_code_reg;  // last-word byte code
  logic [47:0]           dest_reg;       // destination address octets
  logic                  out_valid_next; // output slot after this edge
  tfhd_pkg::tfhd_word_t  word_next;      // word loaded into output slot
  logic                  load_word;      // output slot takes a word
  logic                  take;           // fifo word accepted
  logic                  drain;          // mac takes output word
  logic                  slot_free;      // output slot free this cycle
  logic [14:0]           comb_len;       // combined length field
  logic                  tag_on;         // switch tag insertion enabled
  logic                  is_bpdu;        // destination is bpdu group
  logic                  need_pad;       // frame shorter than minimum
  logic [2:0]            real_bytes;     // bytes in current real word

  assign take      = fifo_valid && fifo_ready;
  assign drain     = mac_valid && mac_ready;
  assign slot_free = !mac_valid || mac_ready;
  assign tag_on    = ctrl_reg[tfhd_pkg::ctrl_tag_ins_bit];
  assign comb_len  = fifo_data[tfhd_pkg::word_cnt_msb:
                               tfhd_pkg::last_bytes_lsb];
  // whole six octets are known only after two data words
  assign is_bpdu   = (dest_reg == tfhd_pkg::bpdu_dest);
  // short frames pad only when crc is appended here
  assign need_pad  = frame_ctl.pad_short &&
                     (words_out_reg < tfhd_pkg::min_frame_words);
  // final word byte count from the two-bit code
  assign real_bytes = (words_left_reg == 13'h0001) ?
                      {1'b0, last_code_reg} + 3'h1 : 3'h4;

  // next state: header, header, counted data, optional pad
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tfhd_pkg::st_hdr0: begin
        if (take) begin
          state_next = tfhd_pkg::st_hdr1;
        end
      end
      tfhd_pkg::st_hdr1: begin
        if (take) begin
          // zero words: nothing to send, back to header
          state_next = (words_left_reg == 13'h0000) ?
                       tfhd_pkg::st_hdr0 : tfhd_pkg::st_data;
        end
      end
      tfhd_pkg::st_data: begin
        if (take && words_left_reg == 13'h0001) begin
          state_next = need_pad && (words_out_reg + 13'h0001 <
                       tfhd_pkg::min_frame_words) ?
                       tfhd_pkg::st_pad : tfhd_pkg::st_hdr0;
        end
      end
      tfhd_pkg::st_pad: begin
        if (load_word && words_out_reg + 13'h0001 >=
            tfhd_pkg::min_frame_words) begin
          state_next = tfhd_pkg::st_hdr0;
        end
      end
      default: begin
        state_next = tfhd_pkg::st_hdr0;
      end
    endcase
  end

  // word loaded into the output slot, invalid bytes zeroed
  always_comb begin
    load_word  = 1'b0;
    word_next  = '0;
    if (state_reg == tfhd_pkg::st_data && take) begin
      load_word        = 1'b1;
      word_next.data   = fifo_data;
      word_next.nbytes = real_bytes;
      word_next.last   = (state_next == tfhd_pkg::st_hdr0);
      if (words_left_reg == 13'h0001) begin
        case (last_code_reg)
          2'h0:    word_next.data = {24'h000000, fifo_data[7:0]};
          2'h1:    word_next.data = {16'h0000, fifo_data[15:0]};
          2'h2:    word_next.data = {8'h00, fifo_data[23:0]};
          default: word_next.data = fifo_data;
        endcase
        // padded frames end on whole zero-filled words
        if (state_next == tfhd_pkg::st_pad) begin
          word_next.nbytes = 3'h4;
        end
      end
    end else if (state_reg == tfhd_pkg::st_pad && slot_free) begin
      load_word        = 1'b1;
      word_next.nbytes = 3'h4;
      word_next.last   = (state_next == tfhd_pkg::st_hdr0);
    end
  end

  assign out_valid_next = load_word || (mac_valid && !mac_ready);

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= tfhd_pkg::st_hdr0;
    end else begin
      state_reg <= state_next;
    end
  end

  // fifo ready from a flop; costs a bubble per data word, no skid needed
  // ready stays low in padding so no word slips into the pad run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fifo_ready <= 1'b0;
    end else begin
      case (state_next)
        tfhd_pkg::st_hdr0: fifo_ready <= 1'b1;
        tfhd_pkg::st_hdr1: fifo_ready <= 1'b1;
        tfhd_pkg::st_data: fifo_ready <= !out_valid_next;
        default:           fifo_ready <= 1'b0;
      endcase
    end
  end

  // output slot toward the mac
  // a held word is never overwritten: loads need a free slot
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mac_valid <= 1'b0;
      mac_word  <= '0;
    end else begin
      mac_valid <= out_valid_next;
      if (load_word) begin
        mac_word <= word_next;
      end
    end
  end

  // counters of the frame body
  // pad words count too, so the pad run ends on the total
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      words_left_reg <= 13'h0000;
      words_out_reg  <= 13'h0000;
      last_code_reg  <= 2'h0;
    end else begin
      if (state_reg == tfhd_pkg::st_hdr0 && take) begin
        // filler is not in these counts, so they are used as given
        words_left_reg <= fifo_data[tfhd_pkg::word_cnt_msb:
                                    tfhd_pkg::word_cnt_lsb];
        last_code_reg  <= fifo_data[tfhd_pkg::last_bytes_msb:
                                    tfhd_pkg::last_bytes_lsb];
        words_out_reg  <= 13'h0000;
      end else begin
        if (state_reg == tfhd_pkg::st_data && take) begin
          words_left_reg <= words_left_reg - 13'h0001;
        end
        if (load_word) begin
          words_out_reg <= words_out_reg + 13'h0001;
        end
      end
    end
  end

  // destination octets from the first two frame words
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dest_reg <= 48'h0;
    end else if (state_reg == tfhd_pkg::st_hdr1 && take) begin
      dest_reg <= 48'h0;
    end else if (state_reg == tfhd_pkg::st_data && take) begin
      if (words_out_reg == 13'h0000) begin
        dest_reg[31:0] <= fifo_data;
      end else if (words_out_reg == 13'h0001) begin
        dest_reg[47:32] <= fifo_data[15:0];
      end
    end
  end

  // frame controls decoded from header word 0
  // control register sampled here and tag bit again at header word 1; later writes wait a frame
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_ctl.vlan_tagged      <= 1'b0;
      frame_ctl.append_crc       <= 1'b0;
      frame_ctl.pad_short        <= 1'b0;
      frame_ctl.offload_active   <= 1'b0;
      frame_ctl.trailer_force    <= 1'b0;
      frame_ctl.trailer_use_seq  <= 1'b0;
      frame_ctl.trailer_suppress <= 1'b0;
      frame_ctl.one_step         <= 1'b0;
      frame_ctl.timestamp        <= 1'b0;
      frame_ctl.forced_fwd       <= 1'b0;
      frame_ctl.frame_bytes      <= 15'h0000;
      hdr0_reg                   <= 32'h0;
    end else if (state_reg == tfhd_pkg::st_hdr0 && take) begin
      hdr0_reg <= fifo_data;
      frame_ctl.vlan_tagged <= fifo_data[tfhd_pkg::vlan_bit];
      // crc already present: nothing appended, auto pad ignored
      frame_ctl.append_crc  <= !fifo_data[tfhd_pkg::crc_incl_bit];
      frame_ctl.pad_short   <= fifo_data[tfhd_pkg::auto_pad_bit] &&
                               !fifo_data[tfhd_pkg::crc_incl_bit];
      frame_ctl.offload_active <=
        ctrl_reg[tfhd_pkg::ctrl_offload_bit] &&
        !fifo_data[tfhd_pkg::offload_off_bit];
      // frame bytes in fifo: length minus bias plus filler
      if (ctrl_reg[tfhd_pkg::ctrl_offload_bit]) begin
        frame_ctl.frame_bytes <= comb_len - tfhd_pkg::len_bias +
                                 tfhd_pkg::offload_pad_sz;
      end else begin
        frame_ctl.frame_bytes <= comb_len - tfhd_pkg::len_bias;
      end
      // switch fields count only with tag insertion enabled
      frame_ctl.trailer_suppress <= tag_on &&
        fifo_data[tfhd_pkg::suppress_bit];
      frame_ctl.trailer_force <= tag_on &&
        fifo_data[tfhd_pkg::force_trailer_bit] &&
        !fifo_data[tfhd_pkg::suppress_bit];
      frame_ctl.trailer_use_seq <= tag_on &&
        fifo_data[tfhd_pkg::use_seq_bit] &&
        fifo_data[tfhd_pkg::force_trailer_bit] &&
        !fifo_data[tfhd_pkg::suppress_bit];
      frame_ctl.one_step   <= tag_on &&
        fifo_data[tfhd_pkg::one_step_bit];
      frame_ctl.timestamp  <= tag_on &&
        fifo_data[tfhd_pkg::timestamp_bit];
      frame_ctl.forced_fwd <= tag_on &&
        fifo_data[tfhd_pkg::forced_fwd_bit];
    end
  end

  // frame controls decoded from header word 1
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_ctl.seq_num   <= 16'h0000;
      frame_ctl.port_mask <= 4'h0;
      frame_ctl.frame_id  <= 32'h0;
    end else if (state_reg == tfhd_pkg::st_hdr1 && take) begin
      if (tag_on) begin
        // sequence kept only where it will be used
        frame_ctl.seq_num <= frame_ctl.trailer_use_seq ?
          fifo_data[tfhd_pkg::seq_msb:tfhd_pkg::seq_lsb] :
          16'h0000;
        frame_ctl.port_mask <= frame_ctl.forced_fwd ?
          fifo_data[tfhd_pkg::port_mask_msb:tfhd_pkg::port_mask_lsb] :
          4'h0;
        frame_ctl.frame_id <= {24'h000000,
                               fifo_data[tfhd_pkg::short_id_msb:0]};
      end else begin
        frame_ctl.seq_num   <= 16'h0000;
        frame_ctl.port_mask <= 4'h0;
        frame_ctl.frame_id  <= fifo_data;
      end
    end
  end

  // disabled-port filtering: forced-forwarded bpdu follows the include bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_ctl.filter_disabled <= 1'b1;
    end else if (state_reg == tfhd_pkg::st_hdr1 && take) begin
      // safe default until the address is known
      frame_ctl.filter_disabled <= 1'b1;
    end else if (state_reg == tfhd_pkg::st_data && take &&
                 words_out_reg == 13'h0002) begin
      frame_ctl.filter_disabled <= !(frame_ctl.forced_fwd && is_bpdu) ||
                                   hdr0_reg[tfhd_pkg::incl_filter_bit];
    end
  end

  // frame active from header end until the last word leaves
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_active <= 1'b0;
    end else if (state_next == tfhd_pkg::st_data ||
                 state_next == tfhd_pkg::st_pad) begin
      frame_active <= 1'b1;
    end else if (drain && mac_word.last) begin
      frame_active <= 1'b0;
    end
  end

  // software control register and frame counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg      <= tfhd_pkg::ctrl_reset_val;
      frame_cnt_reg <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == tfhd_pkg::ctrl_reg_off) begin
        // only the two defined control bits are kept
        ctrl_reg <= {30'h0, reg_wdata[1:0]};
      end
      if (reg_wr && reg_addr == tfhd_pkg::frame_cnt_reg_off) begin
        // a frame ending in the clearing cycle still counts
        frame_cnt_reg <= {31'h0, drain && mac_word.last};
      end else if (drain && mac_word.last) begin
        frame_cnt_reg <= frame_cnt_reg + 32'h1;
      end
    end
  end

  // read data stands in the cycle after the strobe only
  // unmapped offsets read zero; the port never stalls the master
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        tfhd_pkg::ctrl_reg_off:      reg_rdata <= ctrl_reg;
        tfhd_pkg::hdr_word0_reg_off: reg_rdata <= hdr0_reg;
        tfhd_pkg::frame_id_reg_off:  reg_rdata <= frame_ctl.frame_id;
        tfhd_pkg::frame_cnt_reg_off: reg_rdata <= frame_cnt_reg;
        tfhd_pkg::frame_len_reg_off: reg_rdata <=
          {16'h0000, frame_active, frame_ctl.frame_bytes};
        default:                     reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule : tfhd_decoder

// ---- sim/tfhd_props.sv ----
// assertion checker watching the tx frame header decoder ports
module tfhd_props (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst_b,
  // register port
  input wire logic [7:0]           reg_addr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  // mac side and controls
  input wire tfhd_pkg::tfhd_word_t mac_word,
  input wire logic                 mac_valid,
  input wire logic                 mac_ready,
  input wire tfhd_pkg::tfhd_ctl_t  frame_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // read data only in the cycle after a read strobe
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");
  // unmapped place reads as zero
  a_unmapped_rd: assert property (reg_rd && reg_addr == 8'h40
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  // length readback is the held byte count, upper half zero
  a_len_readback: assert property (reg_rd
    && reg_addr == tfhd_pkg::frame_len_reg_off |=> reg_rdata[31:16] == 16'h0
    && reg_rdata[14:0] == $past(frame_ctl.frame_bytes))
    else $error("length readback wrong");
  // a word waits whole until the mac takes it
  a_word_held: assert property (mac_valid && !mac_ready
    |=> mac_valid && $stable(mac_word)) else $error("mac word dropped");
  // byte count 1 to 4
  a_byte_count: assert property (mac_valid
    |-> mac_word.nbytes inside {[3'h1:3'h4]})
    else $error("byte count out of range");
  // bytes past the count are zero
  a_tail_zero: assert property (mac_valid && mac_word.nbytes != 3'h4
    |-> (mac_word.data >> {mac_word.nbytes, 3'h0}) == 32'h0)
    else $error("invalid bytes not zero");
  // crc included means no pad
  a_crc_no_pad: assert property (frame_ctl.pad_short
    |-> frame_ctl.append_crc) else $error("pad with crc");
  // provided sequence needs forced trailer
  a_seq_needs_force: assert property (frame_ctl.trailer_use_seq
    |-> frame_ctl.trailer_force) else $error("seq without force");
  // suppress wins over force
  a_force_vs_suppr: assert property (frame_ctl.trailer_force
    |-> !frame_ctl.trailer_suppress) else $error("force under suppress");
endmodule : tfhd_props

bind tfhd_decoder tfhd_props i_props (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mac_word(mac_word), .mac_valid(mac_valid),
  .mac_ready(mac_ready), .frame_ctl(frame_ctl));

// ---- sim/tfhd_dma_model.sv ----
// transmit dma model feeding header and frame words to the fifo port
module tfhd_dma_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // pace and fifo handshake
  input  wire logic        slow,
  input  wire logic        fifo_ready,
  output logic      [31:0] fifo_data,
  output logic             fifo_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$]; // words from the bench, header first
  logic        gap;  // idle cycle after each word when slow
  // hold each word until taken, then offer the next
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fifo_valid <= 1'b0;
      fifo_data  <= 32'h0;
      gap        <= 1'b0;
    end else if (!fifo_valid || fifo_ready) begin
      if (q.size() > 0 && !(slow && gap)) begin
        fifo_data  <= q.pop_front();
        fifo_valid <= 1'b1;
        gap        <= 1'b1;
      end else begin
        // idle bus shows no stale word
        fifo_valid <= 1'b0;
        fifo_data  <= ~fifo_data;
        gap        <= 1'b0;
      end
    end
  end
endmodule : tfhd_dma_model

// ---- sim/tb_top.sv ----
// self-checking bench for the tx frame header decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clock, rst_b;           // clock and reset
  logic [7:0]           reg_addr;               // register port
  logic [31:0]          reg_wdata, reg_rdata, rd;
  logic                 reg_wr, reg_rd, slow;
  logic [31:0]          fifo_data;              // fifo port
  logic                 fifo_valid, fifo_ready;
  logic                 mac_valid, mac_ready, frame_active;
  tfhd_pkg::tfhd_word_t mac_word;
  tfhd_pkg::tfhd_word_t rx[$];                  // words the mac took
  tfhd_pkg::tfhd_ctl_t  frame_ctl, cs;          // cs: last active ctl
  int                   mismatches, n_checks, cyc;
  logic [63:0]          da = 64'hFFFF_FF01_FFFF_FF00; // first data words
  // header word 0 flag bits
  localparam logic [15:0] crc_b = 16'h1 << tfhd_pkg::crc_incl_bit;
  localparam logic [15:0] pad_b = 16'h1 << tfhd_pkg::auto_pad_bit;
  localparam logic [15:0] vl_b  = 16'h1 << tfhd_pkg::vlan_bit;
  localparam logic [15:0] sw_b  = (16'h1 << tfhd_pkg::use_seq_bit)
    | (16'h1 << tfhd_pkg::force_trailer_bit)
    | (16'h1 << tfhd_pkg::one_step_bit)
    | (16'h1 << tfhd_pkg::timestamp_bit)
    | (16'h1 << tfhd_pkg::forced_fwd_bit);
  localparam logic [15:0] sup_b = 16'h1 << tfhd_pkg::suppress_bit;
  localparam logic [15:0] off_b = 16'h1 << tfhd_pkg::offload_off_bit;
  localparam logic [31:0] w1sw  = 32'hABCD_053C; // seq, mask 5, id

  tfhd_decoder i_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fifo_data(fifo_data), .fifo_valid(fifo_valid),
    .fifo_ready(fifo_ready), .mac_word(mac_word), .mac_valid(mac_valid),
    .mac_ready(mac_ready), .frame_ctl(frame_ctl),
    .frame_active(frame_active));
  tfhd_dma_model i_dma (.clock(clock), .rst_b(rst_b), .slow(slow),
    .fifo_ready(fifo_ready), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid));

  // clock at 100 MHz
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // mac side stalls one cycle in four; collect taken words
  always @(posedge clock) begin
    cyc       <= cyc + 1;
    mac_ready <= (cyc % 4 != 3);
    if (mac_valid && mac_ready) rx.push_back(mac_word);
    if (frame_active) cs <= frame_ctl;
  end

  task automatic stop_test();
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // one-cycle read, data taken in the answer cycle
  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr

  // send header and wc words, wait for n words at the mac
  task automatic frame(input logic [12:0] wc, input logic [1:0] code,
    input logic [15:0] bits, input logic [31:0] w1, input int n);
    int t;
    rx.delete();
    i_dma.q.push_back({1'b0, wc, code, bits});
    i_dma.q.push_back(w1);
    for (int i = 0; i < wc; i++)
      i_dma.q.push_back(i < 2 ? da[32 * i +: 32] : 32'hFFFF_FF00 | i);
    t = 0;
    while (rx.size() < n && t < 600) begin
      @(posedge clock);
      t++;
    end
    repeat (4) @(posedge clock);
    chk("word count", n, rx.size());
  endtask : frame

  // reset values, unmapped place ignored
  task automatic t_regs();
    rdr(tfhd_pkg::ctrl_reg_off);
    chk("ctrl reset", tfhd_pkg::ctrl_reset_val, rd);
    wr(8'h40, 32'hFFFF_FFFF);
    rdr(8'h40);
    chk("unmapped", 32'h0, rd);
    rdr(tfhd_pkg::ctrl_reg_off);
    chk("ctrl kept", 32'h0, rd);
  endtask : t_regs

  // every last-word code, length and id readback
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      frame(13'h3, c[1:0], crc_b, 32'h1234_5670 + c, 3);
      chk("nbytes", c + 1, rx[2].nbytes);
      chk("tail", 32'hFFFF_FF02 & (32'hFFFF_FFFF >> (8 * (3 - c))),
          rx[2].data);
      chk("last", 1, rx[2].last);
      chk("vlan", 0, cs.vlan_tagged);
      rdr(tfhd_pkg::frame_len_reg_off);
      chk("length", 9 + c, rd);
      rdr(tfhd_pkg::frame_id_reg_off);
      chk("frame id", 32'h1234_5670 + c, rd);
    end
    rdr(tfhd_pkg::frame_cnt_reg_off);
    chk("frames", 4, rd);
    wr(tfhd_pkg::frame_cnt_reg_off, 32'h1);
    rdr(tfhd_pkg::frame_cnt_reg_off);
    chk("frames clr", 0, rd);
  endtask : t_codes

  // short frame padded, and not padded when crc is included
  task automatic t_pad();
    frame(13'h2, 2'h3, pad_b, 32'h0, 15);
    chk("pad flag", 1, cs.pad_short);
    chk("pad last", 1, rx[14].last);
    chk("pad data", 0, rx[14].data);
    chk("real last", 0, rx[1].last);
    slow <= 1'b1;
    frame(13'h2, 2'h3, pad_b | crc_b | vl_b, 32'h0, 2);
    slow <= 1'b0;
    chk("no pad", 0, cs.pad_short);
    chk("no crc", 0, cs.append_crc);
    chk("vlan", 1, cs.vlan_tagged);
  endtask : t_pad

  // switch fields with tagging on, suppress, then tagging off
  task automatic t_switch();
    wr(tfhd_pkg::ctrl_reg_off, 32'h3);
    frame(13'h3, 2'h3, sw_b | crc_b, w1sw, 3);
    chk("seq", 16'hABCD, cs.seq_num);
    chk("mask", 4'h5, cs.port_mask);
    chk("id", 8'h3C, cs.frame_id);
    chk("flags", 4'hF, {cs.one_step, cs.timestamp, cs.forced_fwd,
        cs.trailer_force});
    chk("filter", 1, cs.filter_disabled);
    chk("offload", 1, cs.offload_active);
    chk("bytes", 14, cs.frame_bytes);
    frame(13'h3, 2'h3, sw_b | crc_b | sup_b | off_b, w1sw, 3);
    chk("suppressed", 0, {cs.trailer_force, cs.trailer_use_seq});
    chk("suppress", 1, cs.trailer_suppress);
    chk("seq off", 0, cs.seq_num);
    chk("offload off", 0, cs.offload_active);
    wr(tfhd_pkg::ctrl_reg_off, 32'h2);
    frame(13'h3, 2'h3, sw_b | crc_b, w1sw, 3);
    chk("untagged", 0, {cs.seq_num, cs.port_mask, cs.forced_fwd,
        cs.timestamp});
    chk("full id", w1sw, cs.frame_id);
  endtask : t_switch

  // bpdu forced forwarding: include bit decides disabled-port filter
  task automatic t_bpdu();
    wr(tfhd_pkg::ctrl_reg_off, 32'h1);
    da = {16'hFFFF, tfhd_pkg::bpdu_dest};
    for (int k = 0; k < 2; k++) begin
      frame(13'h3, 2'h3, crc_b | (16'h1 << tfhd_pkg::forced_fwd_bit)
            | (16'(k) << tfhd_pkg::incl_filter_bit), w1sw, 3);
      chk("bpdu filter", k, cs.filter_disabled);
    end
  endtask : t_bpdu

  // watchdog cuts a hang short
  initial begin
    #300us;
    mismatches++;
    stop_test();
  end
  // main sequence
  initial begin
    rst_b     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    slow      = 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_codes();
    t_pad();
    t_switch();
    t_bpdu();
    stop_test();
  end
endmodule : tb_top
